// file: verilog/hbt_pkg.sv
`default_nettype none
package hbt_pkg;
  // register geometry
  localparam int          REG_W          = 16;
  localparam int          ADDR_W         = 5;
  localparam int          SEL_W          = 3;
  localparam int          NUM_BRIDGES    = 4;
  localparam int          NUM_SETS       = 4;
  // offsets within a bank
  localparam logic [4:0]  OFS_TIMING_MAP = 5'h04;
  localparam logic [4:0]  OFS_TIMING_SETS = 5'h05;
  localparam logic [4:0]  OFS_OUTPUT_MODE = 5'h06;
  localparam logic [4:0]  OFS_EXTRA_SETS = 5'h1d;
  // bank of the active and freewheel copies
  localparam logic        BANK_ACTIVE    = 1'b0;
  localparam logic        BANK_FREEWHEEL = 1'b1;
  // field positions inside the timing-set register
  localparam int          POS_DEAD1      = 0;
  localparam int          POS_BLANK1     = 3;
  localparam int          POS_DEAD2      = 6;
  localparam int          POS_BLANK2     = 9;
  localparam int          POS_DEAD3      = 12;
  // field positions inside the extra-set register
  localparam int          POS_XBLANK3    = 0;
  localparam int          POS_XDEAD4     = 3;
  localparam int          POS_XBLANK4    = 6;
  // reset values and write masks
  localparam logic [15:0] RST_TIMING_SETS = 16'h4924;
  localparam logic [15:0] MASK_TIMING_SETS = 16'h7fff;
  localparam logic [15:0] RST_EXTRA_SETS = 16'h0124;
  localparam logic [15:0] MASK_EXTRA_SETS = 16'h01ff;
  localparam logic [15:0] RST_TIMING_MAP = 16'h0000;
  localparam logic [15:0] MASK_TIMING_MAP = 16'h00ff;
  localparam logic [15:0] RST_OUTPUT_MODE = 16'h0000;
  localparam logic [15:0] MASK_OUTPUT_MODE = 16'h00ff;
  // bridge mode codes
  localparam logic [1:0]  MODE_HIZ       = 2'h0;
  localparam logic [1:0]  MODE_LOW_ON    = 2'h1;
  localparam logic [1:0]  MODE_HIGH_ON   = 2'h2;
  // clock rate and timing tables in ns
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          DEAD_NS [8] = '{375, 625, 1000, 1500,
                                          2000, 3000, 4000, 16000};
  localparam int          BLANK_NS [8] = '{625, 1000, 1250, 1500,
                                           2000, 3000, 4000, 16000};
  localparam int          CNT_W          = 13;
  // least times, rounded up to whole cycles
  function automatic logic [12:0] deadCycles(input logic [2:0] code);
    deadCycles = 13'((DEAD_NS[code] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction
  function automatic logic [12:0] blankCycles(input logic [2:0] code);
    blankCycles = 13'((BLANK_NS[code] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction
endpackage
`default_nettype wire

// file: verilog/hbt_gate_if.sv
`timescale 1ns/1ps
`default_nettype none
// per-bridge timing and gate signals between top and bridge sequencer
interface hbt_gate_if;
  logic [1:0]  mode;       // requested bridge mode
  logic [12:0] deadCnt;    // dead time in cycles
  logic [12:0] blankCnt;   // blank time in cycles
  logic        vdsFault;   // raw overvoltage detection
  logic        highOn;     // high-side gate
  logic        lowOn;      // low-side gate
  logic        vdsError;   // qualified overvoltage
  modport ctrl (output mode, deadCnt, blankCnt, vdsFault,
                input highOn, lowOn, vdsError);
  modport seq (input mode, deadCnt, blankCnt, vdsFault,
               output highOn, lowOn, vdsError);
endinterface
`default_nettype wire

// file: verilog/hbt_bridge_seq.sv
`timescale 1ns/1ps
`default_nettype none
// one half-bridge: dead time between gates, blanking after turn-on
module hbt_bridge_seq
  import hbt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bridge link
  hbt_gate_if.seq  gate
);
  typedef enum logic [3:0] {
    ST_OFF   = 4'b0001,
    ST_DEAD  = 4'b0010,
    ST_HIGH  = 4'b0100,
    ST_LOW   = 4'b1000
  } hbt_state_e;

  hbt_state_e       state;       // current gate state
  hbt_state_e       next_state;
  logic [12:0]      cnt;         // dead or blank countdown
  logic [12:0]      next_cnt;
  logic             target;      // gate to open after dead time, 1 = high
  logic             next_target;

  // desired side from mode code; code 11 falls back to off
  logic wantHigh;
  logic wantLow;
  assign wantHigh = (gate.mode == MODE_HIGH_ON);
  assign wantLow  = (gate.mode == MODE_LOW_ON);

  // next state: every turn-on passes through dead time first; turn-off is immediate
  always_comb begin
    next_state  = state;
    next_cnt    = (cnt != '0) ? cnt - 13'd1 : cnt;
    next_target = target;
    unique case (state)
      ST_OFF: begin
        if (wantHigh || wantLow) begin
          next_state  = ST_DEAD;
          next_target = wantHigh;
          next_cnt    = gate.deadCnt;
        end
      end
      ST_DEAD: begin
        if (!(wantHigh || wantLow)) begin
          next_state = ST_OFF;
        end else if (wantHigh != target) begin
          // request flipped mid-wait: restart the full gap
          next_target = wantHigh;
          next_cnt    = gate.deadCnt;
        end else if (cnt <= 13'd1) begin
          next_state = target ? ST_HIGH : ST_LOW;
          next_cnt   = gate.blankCnt;
        end
      end
      ST_HIGH: begin
        if (!wantHigh) begin
          next_state  = wantLow ? ST_DEAD : ST_OFF;
          next_target = 1'b0;
          next_cnt    = gate.deadCnt;
        end
      end
      ST_LOW: begin
        if (!wantLow) begin
          next_state  = wantHigh ? ST_DEAD : ST_OFF;
          next_target = 1'b1;
          next_cnt    = gate.deadCnt;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state  <= ST_OFF;
      cnt    <= '0;
      target <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      target <= next_target;
    end
  end

  // gates never overlap: only one on-state exists
  assign gate.highOn   = (state == ST_HIGH);
  assign gate.lowOn    = (state == ST_LOW);
  // detections masked while blank count runs
  assign gate.vdsError = gate.vdsFault && (gate.highOn || gate.lowOn)
                         && (cnt == '0);
endmodule
`default_nettype wire

// file: verilog/hbt_timing_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - active dead codes decode 375ns..16us, default 100
// - active blank codes decode 625ns..16us, default 100
// - freewheel set register only in bank 1
// - freewheel set register resets to 0x4924
// - five 3-bit selectors at documented bit fields
// - freewheel dead codes decode 375ns..16us
// - freewheel blank codes decode 625ns..16us
// - sets 3 blank, 4 from separate register
// - mode register, four 2-bit bridge fields
// - mode 00/11 off, 01 low, 10 high
// - reserved bits read zero, not writable
// - active set register same offset bank 0
// - map register picks timing set per bridge
module hbt_timing_regs
  import hbt_pkg::*;
#(
  parameter int NBRIDGE = NUM_BRIDGES  // half-bridges driven
)(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register port from serial front end
  input  wire logic               regBank,
  input  wire logic [ADDR_W-1:0]  regAddr,
  input  wire logic               regWrite,
  input  wire logic [REG_W-1:0]   regWdata,
  output logic      [REG_W-1:0]   regRdata,
  output logic                    regHit,
  // gate driver side
  input  wire logic [NBRIDGE-1:0] activeIsHigh,
  input  wire logic [NBRIDGE-1:0] vdsFault,
  output logic      [NBRIDGE-1:0] highGate,
  output logic      [NBRIDGE-1:0] lowGate,
  output logic      [NBRIDGE-1:0] vdsError
);
  // register map, 16-bit words at 5-bit offsets
  //   0x04  bridge to timing-set map, two bits a bridge, unbanked
  //   0x05  timing sets 1 to 3, banked: bank 0 active, bank 1 freewheel
  //   0x06  bridge output mode, two bits a bridge, unbanked
  //   0x1d  blank 3, dead 4 and blank 4 codes, banked like 0x05
  // any other offset ignores writes and reads back zero; reserved
  // bits are dropped on the way in, so a read never shows a bit that
  // software could not have set
  // the bank bit is a level that the serial front end holds together
  // with the offset; it is only looked at for the banked words

  // timing codes become cycle counts here, once per bridge, so each
  // sequencer only ever sees a ready count; every count is the typical
  // time rounded up to whole clock periods, which keeps the real gap at
  // or above the typical figure, never below it
  // code 111 is the longest time on both tables; the gate current that
  // must go with it lives outside this block and is not checked here

  // active and freewheel words are fully separate flops: writing one
  // bank never disturbs the other, and both reset to the same pattern
  // register storage, one copy per bank for the timing sets
  // full 16-bit words keep the read path plain; reserved bits are held
  // at zero by the write masks and cost no real storage
  logic [REG_W-1:0] setsAct;      // active timing sets, bank 0
  logic [REG_W-1:0] setsFw;       // freewheel timing sets, bank 1
  logic [REG_W-1:0] extraAct;     // active sets 3 blank, 4
  logic [REG_W-1:0] extraFw;      // freewheel sets 3 blank, 4
  logic [REG_W-1:0] timingMap;    // bridge to set mapping
  logic [REG_W-1:0] outputMode;   // bridge mode fields
  logic [REG_W-1:0] next_setsAct;
  logic [REG_W-1:0] next_setsFw;
  logic [REG_W-1:0] next_extraAct;
  logic [REG_W-1:0] next_extraFw;
  logic [REG_W-1:0] next_timingMap;
  logic [REG_W-1:0] next_outputMode;

  // address decode; bank only matters for banked registers
  // the decode is on offset alone, so the hit flag is the same in
  // either bank and software can probe a word without a bank switch
  logic hitSets;   // timing sets 1 to 3, banked
  logic hitExtra;  // remaining set codes, banked
  logic hitMap;    // bridge to set map
  logic hitMode;   // bridge output mode
  // offset compare only; regHit tells the front end the word exists
  assign hitSets  = (regAddr == OFS_TIMING_SETS);
  assign hitExtra = (regAddr == OFS_EXTRA_SETS);
  assign hitMap   = (regAddr == OFS_TIMING_MAP);
  assign hitMode  = (regAddr == OFS_OUTPUT_MODE);
  assign regHit   = hitSets | hitExtra | hitMap | hitMode;

  // writes, masked so reserved bits stay zero
  // a write lands at the clock edge that samples the strobe; the two
  // bank copies share one offset, so the bank bit alone keeps a write
  // to the freewheel copy from touching the active one
  always_comb begin
    next_setsAct    = setsAct;
    next_setsFw     = setsFw;
    next_extraAct   = extraAct;
    next_extraFw    = extraFw;
    next_timingMap  = timingMap;
    next_outputMode = outputMode;
    // hold by default; only a strobed write to a hit offset moves a word
    if (regWrite) begin
      if (hitSets && regBank == BANK_FREEWHEEL) begin
        next_setsFw = regWdata & MASK_TIMING_SETS;
      end
      if (hitSets && regBank == BANK_ACTIVE) begin
        next_setsAct = regWdata & MASK_TIMING_SETS;
      end
      if (hitExtra && regBank == BANK_FREEWHEEL) begin
        next_extraFw = regWdata & MASK_EXTRA_SETS;
      end
      if (hitExtra && regBank == BANK_ACTIVE) begin
        next_extraAct = regWdata & MASK_EXTRA_SETS;
      end
      if (hitMap) begin
        next_timingMap = regWdata & MASK_TIMING_MAP;
      end
      if (hitMode) begin
        next_outputMode = regWdata & MASK_OUTPUT_MODE;
      end
    end
  end

  // register update; reset pattern puts every selector at code 100
  // with every selector at 100 both tables start at a middle time, long
  // enough to be safe on any bridge before software sets its own
  always_ff @(posedge clk) begin
    if (rst) begin
      setsAct    <= RST_TIMING_SETS;
      setsFw     <= RST_TIMING_SETS;
      extraAct   <= RST_EXTRA_SETS;
      extraFw    <= RST_EXTRA_SETS;
      timingMap  <= RST_TIMING_MAP;
      outputMode <= RST_OUTPUT_MODE;
    end else begin
      setsAct    <= next_setsAct;
      setsFw     <= next_setsFw;
      extraAct   <= next_extraAct;
      extraFw    <= next_extraFw;
      timingMap  <= next_timingMap;
      outputMode <= next_outputMode;
    end
  end

  // read mux, from flip-flops; unmapped offsets read zero
  // data follows the address by one cycle; a read in the cycle of a
  // write to that word shows the old value, the new one a cycle later
  logic [REG_W-1:0] next_regRdata;
  always_comb begin
    next_regRdata = '0;
    if (hitSets) begin
      next_regRdata = (regBank == BANK_FREEWHEEL) ? setsFw : setsAct;
    end else if (hitExtra) begin
      next_regRdata = (regBank == BANK_FREEWHEEL) ? extraFw : extraAct;
    end else if (hitMap) begin
      next_regRdata = timingMap;
    end else if (hitMode) begin
      next_regRdata = outputMode;
    end
  end
  // registered so the data output never glitches with the address
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // gather the four (dead, blank) pairs for one register copy
  // set 1 sits in the low six bits so the map code times six is the
  // offset of the chosen pair; blank 3 and all of set 4 come from the
  // extra word, the rest from the timing-set word
  function automatic logic [23:0] gatherSets(input logic [15:0] sets,
                                             input logic [15:0] extra);
    gatherSets = {extra[POS_XDEAD4 +: SEL_W], extra[POS_XBLANK4 +: SEL_W],
                  sets[POS_DEAD3 +: SEL_W],   extra[POS_XBLANK3 +: SEL_W],
                  sets[POS_DEAD2 +: SEL_W],   sets[POS_BLANK2 +: SEL_W],
                  sets[POS_DEAD1 +: SEL_W],   sets[POS_BLANK1 +: SEL_W]};
  endfunction

  logic [23:0] pairsAct;  // six-bit {dead, blank} per set, set 1 low
  logic [23:0] pairsFw;
  assign pairsAct = gatherSets(setsAct, extraAct);
  assign pairsFw  = gatherSets(setsFw, extraFw);

  // one sequencer per bridge
  // the pair comes from the copy that belongs to the switch about to
  // turn on: the sequencer samples the counts when it leaves the off,
  // dead or on state, and the mode field then already names the side
  // it heads for, so the choice follows the mode, not the state
  genvar b;
  generate
    for (b = 0; b < NBRIDGE; b++) begin : g_bridge
      hbt_gate_if  link ();
      logic [1:0]  setSel;   // chosen timing set
      logic        headHigh; // requested side is the high switch
      logic        useAct;   // switch turning on is the active one
      logic [5:0]  pair;     // selected dead and blank codes
      assign setSel   = timingMap[2*b +: 2];
      assign headHigh = (outputMode[2*b +: 2] == MODE_HIGH_ON);
      // active copy when the active side switches on, else freewheel
      assign useAct   = (headHigh == activeIsHigh[b]);
      assign pair     = useAct ? pairsAct[6*setSel +: 6]
                               : pairsFw[6*setSel +: 6];
      // mode field straight through; code 11 is handled as off
      assign link.mode     = outputMode[2*b +: 2];
      // codes to cycle counts; one table serves both copies
      assign link.deadCnt  = deadCycles(pair[5:3]);
      assign link.blankCnt = blankCycles(pair[2:0]);
      assign link.vdsFault = vdsFault[b];
      assign highGate[b]   = link.highOn;
      assign lowGate[b]    = link.lowOn;
      assign vdsError[b]   = link.vdsError;
      hbt_bridge_seq u_seq (
        .clk  (clk),
        .rst  (rst),
        .gate (link.seq)
      );
    end
  endgenerate
endmodule
`default_nettype wire

// file: bench/hbt_timing_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watcher for the timing register block
module hbt_timing_regs_monitor
  import hbt_pkg::*;
#(
  parameter int NBRIDGE = NUM_BRIDGES  // half-bridges watched
)(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // register port
  input wire logic               regBank,
  input wire logic [ADDR_W-1:0]  regAddr,
  input wire logic               regWrite,
  input wire logic [REG_W-1:0]   regWdata,
  input wire logic [REG_W-1:0]   regRdata,
  input wire logic               regHit,
  // gate side
  input wire logic [NBRIDGE-1:0] activeIsHigh,
  input wire logic [NBRIDGE-1:0] vdsFault,
  input wire logic [NBRIDGE-1:0] highGate,
  input wire logic [NBRIDGE-1:0] lowGate,
  input wire logic [NBRIDGE-1:0] vdsError
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  hit_decode_a: assert property (
    regHit == (regAddr == OFS_TIMING_MAP ||
    regAddr == OFS_TIMING_SETS || regAddr == OFS_OUTPUT_MODE ||
    regAddr == OFS_EXTRA_SETS)) else $error("hit flag wrong");
  dead_read_a: assert property (!regHit |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  mode_upper_a: assert property (regAddr == OFS_OUTPUT_MODE |=>
    regRdata[15:8] == 8'h00) else $error("mode high bits set");
  sets_top_a: assert property (regAddr == OFS_TIMING_SETS |=>
    !regRdata[15]) else $error("sets bit 15 set");
  mode_readback_a: assert property ((regWrite &&
    regAddr == OFS_OUTPUT_MODE) ##1 (!regWrite && regAddr == OFS_OUTPUT_MODE)
    |=> regRdata == ($past(regWdata, 2) & 16'h00ff))
    else $error("mode readback wrong");
  bank_readback_a: assert property (
    (regWrite && regAddr == OFS_TIMING_SETS) ##1 (!regWrite &&
    regAddr == OFS_TIMING_SETS && regBank == $past(regBank))
    |=> regRdata == ($past(regWdata, 2) & MASK_TIMING_SETS))
    else $error("bank readback wrong");
  no_shoot_a: assert property ((highGate & lowGate) == '0)
    else $error("both gates on");
  dead_gap_a: assert property (
    $fell(lowGate[0]) |-> !highGate[0] [*8])
    else $error("no dead gap");
  blank_mask_a: assert property (
    $rose(highGate[0]) |-> !vdsError[0] [*8])
    else $error("fault not blanked");
  err_qualify_a: assert property ((vdsError &
    ~(vdsFault & (highGate | lowGate))) == '0)
    else $error("error without fault");
  off_now_a: assert property (
    (regWrite && regAddr == OFS_OUTPUT_MODE &&
    regWdata[7:0] == 8'h00) |-> ##[1:2] (highGate | lowGate) == '0)
    else $error("gates not off");
endmodule
bind hbt_timing_regs hbt_timing_regs_monitor #(.NBRIDGE(NBRIDGE))
  hbt_timing_regs_monitor_inst (.clk(clk), .rst(rst), .regBank(regBank),
  .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
  .regRdata(regRdata), .regHit(regHit), .activeIsHigh(activeIsHigh),
  .vdsFault(vdsFault), .highGate(highGate), .lowGate(lowGate),
  .vdsError(vdsError));
`default_nettype wire

// file: bench/hbt_timing_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// random register traffic, then timed gate sequencing on bridge 0
module hbt_timing_regs_tb_top
  import hbt_pkg::*;
;
  logic        clk, rst, regBank, regWrite, regHit;  // control
  logic [4:0]  regAddr;                             // offset
  logic [15:0] regWdata, regRdata, d;               // data
  logic [3:0]  actHi, fault, hiG, loG, err;         // gate side
  logic [15:0] setsM [2];                           // both bank copies
  logic [2:0]  c;                                   // timing code
  logic        b;                                   // bank pick
  int          badCount = 0;                        // mismatches
  int          numChecks = 0;                       // compares
  int dNs [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
  int bNs [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

  hbt_timing_regs #(.NBRIDGE(4)) hbt_timing_regs_inst (.clk(clk),
    .rst(rst), .regBank(regBank), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .regHit(regHit),
    .activeIsHigh(actHi), .vdsFault(fault), .highGate(hiG),
    .lowGate(loG), .vdsError(err));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one write: strobe for one cycle, address held one more
  task automatic wr(logic bk, logic [4:0] a, logic [15:0] v);
    @(negedge clk);
    regBank = bk;
    regAddr = a;
    regWdata = v;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask

  // registered read data lands one cycle after the address
  task automatic rd(logic bk, logic [4:0] a, logic [15:0] e);
    @(negedge clk);
    regBank = bk;
    regAddr = a;
    @(negedge clk);
    check("rdata", regRdata, e);
  endtask

  // same code in every dead and blank field of one bank
  task automatic setAll(logic bk, logic [2:0] k);
    wr(bk, OFS_TIMING_SETS, {1'b0, k, k, k, k, k});
    wr(bk, OFS_EXTRA_SETS, {7'h00, k, k, k});
  endtask

  function automatic logic probe(int s);
    return s == 0 ? hiG[0] : s == 1 ? loG[0] : err[0];
  endfunction

  // count cycles until a bridge 0 signal rises; bounded
  task automatic waitFor(int s, int e);
    int n;
    n = 0;
    while (probe(s) !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) begin
      // a wait that runs out counts once and ends the run
      badCount++;
      wrapUp();
    end else begin
      check("cycles", 16'(n >= e - 1 && n <= e + 2), 16'h0001);
    end
  endtask

  initial begin
    rst = 1'b1;
    regBank = 1'b0;
    regAddr = 5'h00;
    regWrite = 1'b0;
    regWdata = 16'h0000;
    void'($urandom(32'h3f2ac0e5));
    actHi = 4'($urandom) | 4'h1;   // bridge 0 high side is active
    fault = 4'($urandom) | 4'h1;   // bridge 0 fault held on
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd(1'b0, OFS_TIMING_SETS, 16'h4924);
    rd(1'b1, OFS_TIMING_SETS, 16'h4924);
    rd(1'b1, OFS_EXTRA_SETS, 16'h0124);
    rd(1'b0, OFS_OUTPUT_MODE, 16'h0000);
    rd(1'b0, OFS_TIMING_MAP, 16'h0000);
    setsM = '{16'h4924, 16'h4924};
    // banks kept apart, reserved bits dropped, dead offset ignored
    repeat (12) begin
      d = 16'($urandom);
      b = 1'($urandom);
      setsM[b] = d & 16'h7fff;
      wr(b, OFS_TIMING_SETS, d);
      wr(b, 5'h1f, d);
      rd(b, OFS_TIMING_SETS, setsM[b]);
      rd(!b, OFS_TIMING_SETS, setsM[!b]);
      rd(b, 5'h1f, 16'h0000);
      wr(b, OFS_OUTPUT_MODE, d);
      rd(!b, OFS_OUTPUT_MODE, d & 16'h00ff);
    end
    wr(1'b0, OFS_OUTPUT_MODE, 16'h0000);
    // every code on both sides, each map selector
    // code 111 relies on software keeping gate current low
    for (int k = 0; k < 16; k++) begin
      c = k[2:0];
      setAll(1'b0, c);
      setAll(1'b1, ~c);
      wr(1'b0, OFS_TIMING_MAP, 16'($urandom) & 16'h00fc | 16'(k[1:0]));
      wr(1'b0, OFS_OUTPUT_MODE, k[3] ? 16'h0002 : 16'h0001);
      c = k[3] ? c : ~c;
      waitFor(k[3] ? 0 : 1, (dNs[c] + 3) / 4);
      waitFor(2, (bNs[c] + 3) / 4);
      wr(1'b0, OFS_OUTPUT_MODE, 16'h0003);
      @(negedge clk);
      check("gates", 16'({hiG, loG}), 16'h0000);
    end
    wrapUp();
  end
endmodule
`default_nettype wire
